// ==== clw_bridge.sv ====
// Implementation choices: the address map and the AXI4-Lite register port.
`include "clw_defs.svh"
module clw_bridge #(
    parameter int ADDR_W = 8,
    parameter int FIFO_DEPTH = 2
) (
    input logic aclk,
    input logic aresetn,
    input logic [ADDR_W-1:0] awaddr,
    input logic awvalid,
    output logic awready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input logic bready,
    input logic [ADDR_W-1:0] araddr,
    input logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input logic rready,
    input logic power_down_n,
    input logic pll_locked,
    input logic [1:0] multiplier_select,
    output logic [7:0] pll_multiplier,
    input logic master_role,
    input logic dc_clk,
    input logic host_wr_n,
    input logic host_ad,
    input logic host_cs1_n,
    input logic host_cs2_n,
    input logic [17:0] host_data,
    input clw_pkg::clw_lane_t lane0_rx,
    output clw_pkg::clw_lane_t lane0_tx,
    output logic lane0_en,
    input clw_pkg::clw_lane_t lane1_rx,
    output clw_pkg::clw_lane_t lane1_tx,
    output logic lane1_en,
    output logic disp_wr_n,
    output logic disp_ad,
    output logic disp_cs1_n,
    output logic disp_cs2_n,
    output logic [17:0] disp_data
);
    import clw_pkg::*;
    localparam int PW = $clog2(FIFO_DEPTH);
    // ==========================================
    // Start-up domain (input clock)
    logic [6:0] a_meta_reg, a_s_reg;
    logic pd_s, lock_s, stop_s, sleep_a, start_ok, ctrl_en_reg, clk_tgl_reg, link_ready_reg;
    logic [1:0] sel_s, flags_s, clr_tgl_reg;
    logic [10:0] keep_cnt_reg;
    logic [7:0] pll_mult_reg;
    logic stop_reg;
    logic [1:0] flag_reg;
    always_ff @(posedge aclk) begin
        a_meta_reg <= {power_down_n, pll_locked, multiplier_select, stop_reg, flag_reg};
        a_s_reg <= a_meta_reg;
    end
    assign pd_s = a_s_reg[6];
    assign lock_s = a_s_reg[5];
    assign sel_s = a_s_reg[4:3];
    assign stop_s = a_s_reg[2];
    assign flags_s = a_s_reg[1:0];
    assign sleep_a = !pd_s || stop_s;
    assign start_ok = lock_s && ctrl_en_reg && (sel_s != `CLW_SEL_RSVD);
    // Free toggle lets the link side notice a stopped input clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_tgl_reg <= 1'b0;
        end else begin
            clk_tgl_reg <= !clk_tgl_reg;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || sleep_a || !start_ok) begin
            keep_cnt_reg <= 11'h000;
            link_ready_reg <= 1'b0;
        end else begin
            if (keep_cnt_reg != `CLW_KEEPOFF_CYCLES) begin
                keep_cnt_reg <= keep_cnt_reg + 11'h001;
            end
            link_ready_reg <= (keep_cnt_reg == `CLW_KEEPOFF_CYCLES);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_mult_reg <= 8'h00;
        end else begin
            case (sel_s)
                2'h0: pll_mult_reg <= `CLW_MULT_SEL0;
                2'h1: pll_mult_reg <= `CLW_MULT_SEL1;
                2'h2: pll_mult_reg <= `CLW_MULT_SEL2;
                default: pll_mult_reg <= 8'h00;
            endcase
        end
    end
    assign pll_multiplier = pll_mult_reg;
    // ==========================================
    // AXI4-Lite slave
    logic awready_reg, wready_reg, bvalid_reg, aw_got_reg, w_got_reg, wr_fire;
    logic arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] wd_reg, rdata_reg, rd_mux;
    logic [3:0] ws_reg;
    logic rd_hit, wr_hit;
    assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
    assign wr_hit = (aw_addr_reg == `CLW_CTRL_OFF) || (aw_addr_reg == `CLW_STAT_OFF)
        || (aw_addr_reg == `CLW_MULT_OFF);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            aw_addr_reg <= '0;
            wd_reg <= 32'h0000_0000;
            ws_reg <= 4'h0;
        end else begin
            if (awvalid && awready_reg) begin
                aw_addr_reg <= awaddr;
                aw_got_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (wvalid && wready_reg) begin
                wd_reg <= wdata;
                ws_reg <= wstrb;
                w_got_reg <= 1'b1;
                wready_reg <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? 2'h0 : 2'h2;
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
            end
            if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end
    // Writing 1 to a sticky status bit sends a clear toggle to the link side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_en_reg <= `CLW_CTRL_RST;
            clr_tgl_reg <= 2'h0;
        end else if (wr_fire && ws_reg[0]) begin
            if (aw_addr_reg == `CLW_CTRL_OFF) begin
                ctrl_en_reg <= wd_reg[`CLW_CTRL_EN_BIT];
            end
            if (aw_addr_reg == `CLW_STAT_OFF) begin
                clr_tgl_reg <= clr_tgl_reg ^ {wd_reg[`CLW_ST_OVF_BIT], wd_reg[`CLW_ST_DROP_BIT]};
            end
        end
    end
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (araddr)
            `CLW_CTRL_OFF: rd_mux[`CLW_CTRL_EN_BIT] = ctrl_en_reg;
            `CLW_STAT_OFF: rd_mux[5:0] = {sel_s == `CLW_SEL_RSVD, flags_s[1], flags_s[0],
                sleep_a, lock_s, link_ready_reg};
            `CLW_MULT_OFF: rd_mux[7:0] = pll_mult_reg;
            default: rd_hit = 1'b0;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= 2'h0;
        end else if (arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_hit ? 2'h0 : 2'h2;
        end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    // ==========================================
    // Link domain (serial clock)
    logic rst_meta_reg, dc_rst_n_reg, link_ready_dc, master_s, wr_evt, fifo_full, tx_load, tx_idle;
    logic [7:0] d_meta_reg, d_s_reg;
    logic [2:0] d_d_reg;
    logic [21:0] hb_meta_reg, hb_s_reg;
    logic wr_d_reg;
    logic [4:0] stop_cnt_reg, idle_cnt_reg;
    logic [1:0] flag_set, flag_next;
    // Power-down acts as a reset of the whole link side
    always_ff @(posedge dc_clk) begin
        rst_meta_reg <= aresetn && power_down_n;
        dc_rst_n_reg <= rst_meta_reg;
        d_meta_reg <= {lane1_rx, lane0_rx[0], link_ready_reg, master_role, clr_tgl_reg, clk_tgl_reg};
        d_s_reg <= d_meta_reg;
        d_d_reg <= d_s_reg[2:0];
        hb_meta_reg <= {host_wr_n, host_ad, host_cs1_n, host_cs2_n, host_data};
        hb_s_reg <= hb_meta_reg;
        wr_d_reg <= hb_s_reg[21];
    end
    assign master_s = d_s_reg[3];
    assign link_ready_dc = d_s_reg[4] && !stop_reg;
    // Host write is latched on the rising strobe; no chip select means another device
    assign wr_evt = hb_s_reg[21] && !wr_d_reg && !(hb_s_reg[19] && hb_s_reg[18]);
    // Limitation: the input clock must resume long enough for the start-up side to see the stop
    always_ff @(posedge dc_clk) begin
        if (!dc_rst_n_reg || (d_s_reg[0] != d_d_reg[0])) begin
            stop_cnt_reg <= 5'h00;
            stop_reg <= 1'b0;
        end else if (stop_cnt_reg != `CLW_STOP_DC_CYCLES) begin
            stop_cnt_reg <= stop_cnt_reg + 5'h01;
        end else begin
            stop_reg <= 1'b1;
        end
    end
    // ==========================================
    // Write FIFO
    logic [`CLW_ENTRY_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] wptr_reg, rptr_reg;
    logic [PW:0] fifo_cnt_reg;
    assign fifo_full = (fifo_cnt_reg == (PW+1)'(FIFO_DEPTH));
    assign flag_set = {wr_evt && link_ready_dc && fifo_full, wr_evt && !link_ready_dc};
    always_ff @(posedge dc_clk) begin
        if (wr_evt && link_ready_dc && !fifo_full) begin
            fifo_mem[wptr_reg] <= hb_s_reg[20:0];
        end
    end
    always_ff @(posedge dc_clk) begin
        if (!dc_rst_n_reg || !link_ready_dc) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            fifo_cnt_reg <= '0;
        end else begin
            if (wr_evt && !fifo_full) begin
                wptr_reg <= wptr_reg + PW'(1);
            end
            if (tx_load) begin
                rptr_reg <= rptr_reg + PW'(1);
            end
            fifo_cnt_reg <= fifo_cnt_reg + (PW+1)'(wr_evt && !fifo_full) - (PW+1)'(tx_load);
        end
    end
    for (genvar i = 0; i < 2; i++) begin : g_flag
        // Set wins over a clear arriving in the same cycle
        assign flag_next[i] = flag_set[i] || (flag_reg[i] && (d_s_reg[1+i] == d_d_reg[1+i]));
    end
    always_ff @(posedge dc_clk) begin
        if (!dc_rst_n_reg) begin
            flag_reg <= 2'h0;
        end else begin
            flag_reg <= flag_next;
        end
    end
    // ==========================================
    // Serializer
    clw_tx_state_t tx_state_reg;
    logic [3:0] tx_cnt_reg;
    logic [`CLW_FRAME_W-1:0] tx_shift_reg;
    logic bit_sync_reg;
    clw_lane_t tx_lane, lane0_tx_reg, lane1_tx_reg;
    logic lane0_en_reg, lane1_en_reg;
    assign tx_idle = (tx_state_reg == CLW_TX_IDLE);
    assign tx_load = (fifo_cnt_reg != '0) && (tx_idle || (tx_cnt_reg == 4'h0));
    always_ff @(posedge dc_clk) begin
        if (!dc_rst_n_reg || !link_ready_dc) begin
            tx_state_reg <= CLW_TX_IDLE;
            tx_cnt_reg <= 4'h0;
            tx_shift_reg <= '0;
            idle_cnt_reg <= 5'h00;
            bit_sync_reg <= 1'b0;
        end else if (tx_load) begin
            tx_state_reg <= CLW_TX_SEND;
            tx_shift_reg <= {`CLW_START_CODE, fifo_mem[rptr_reg], `CLW_TRAILER};
            tx_cnt_reg <= `CLW_WORD_DC_CYCLES - 4'h1;
            idle_cnt_reg <= 5'h00;
            bit_sync_reg <= 1'b0;
        end else if (!tx_idle) begin
            tx_shift_reg <= {tx_shift_reg[`CLW_FRAME_W-3:0], 2'h0};
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
            if (tx_cnt_reg == 4'h0) begin
                tx_state_reg <= CLW_TX_IDLE;
            end
        end else begin
            // Sync stays armed through the gap so it lands just ahead of the next word
            bit_sync_reg <= bit_sync_reg || (idle_cnt_reg == `CLW_SYNC_GAP_DC - 5'h01);
            if (idle_cnt_reg != `CLW_SYNC_GAP_DC) begin
                idle_cnt_reg <= idle_cnt_reg + 5'h01;
            end
        end
    end
    assign tx_lane = !tx_idle ? tx_shift_reg[`CLW_FRAME_W-1 -: 2]
        : ((bit_sync_reg && tx_load) ? `CLW_SYNC_CODE : 2'h0);
    // Master drives data on pad 0 and clock on pad 1; slave reads them swapped
    always_ff @(posedge dc_clk) begin
        if (!dc_rst_n_reg) begin
            lane0_tx_reg <= 2'h0;
            lane1_tx_reg <= 2'h0;
            lane0_en_reg <= 1'b0;
            lane1_en_reg <= 1'b0;
        end else begin
            lane0_en_reg <= master_s;
            lane1_en_reg <= master_s;
            lane0_tx_reg <= master_s ? tx_lane : 2'h0;
            lane1_tx_reg <= (master_s && link_ready_dc) ? `CLW_CLK_CODE : 2'h0;
        end
    end
    assign lane0_tx = lane0_tx_reg;
    assign lane1_tx = lane1_tx_reg;
    assign lane0_en = lane0_en_reg;
    assign lane1_en = lane1_en_reg;
    // ==========================================
    // Slave receiver and strobe regeneration
    clw_rx_state_t rx_state_reg;
    logic [3:0] rx_cnt_reg, strobe_cnt_reg;
    logic [23:0] rx_shift_reg;
    logic rx_done, disp_wr_n_reg, disp_ad_reg, disp_cs1_n_reg, disp_cs2_n_reg;
    logic [25:0] rx_word;
    logic [17:0] disp_data_reg;
    assign rx_done = (rx_state_reg == CLW_RX_SHIFT) && (rx_cnt_reg == 4'h0);
    assign rx_word = {rx_shift_reg, d_s_reg[7:6]};
    always_ff @(posedge dc_clk) begin
        if (!dc_rst_n_reg || master_s) begin
            rx_state_reg <= CLW_RX_HUNT;
            rx_cnt_reg <= 4'h0;
            rx_shift_reg <= '0;
        end else if (rx_state_reg == CLW_RX_HUNT) begin
            if (d_s_reg[7:6] == `CLW_START_CODE) begin
                rx_state_reg <= CLW_RX_SHIFT;
                rx_cnt_reg <= `CLW_WORD_DC_CYCLES - 4'h2;
            end
        end else begin
            rx_shift_reg <= rx_word[23:0];
            rx_cnt_reg <= rx_cnt_reg - 4'h1;
            if (rx_cnt_reg == 4'h0) begin
                rx_state_reg <= CLW_RX_HUNT;
            end
        end
    end
    // Strobe width counts serial clocks only, never the host's own strobe
    always_ff @(posedge dc_clk) begin
        if (!dc_rst_n_reg) begin
            disp_wr_n_reg <= 1'b1;
            disp_ad_reg <= 1'b1;
            disp_cs1_n_reg <= 1'b1;
            disp_cs2_n_reg <= 1'b1;
            disp_data_reg <= 18'h0_0000;
            strobe_cnt_reg <= 4'h0;
        end else if (rx_done) begin
            {disp_ad_reg, disp_cs1_n_reg, disp_cs2_n_reg, disp_data_reg} <= rx_word[25:5];
            disp_wr_n_reg <= 1'b0;
            strobe_cnt_reg <= `CLW_STROBE_DC_CYCLES - 4'h1;
        end else if (strobe_cnt_reg != 4'h0) begin
            strobe_cnt_reg <= strobe_cnt_reg - 4'h1;
        end else begin
            disp_wr_n_reg <= 1'b1;
            disp_cs1_n_reg <= 1'b1;
            disp_cs2_n_reg <= 1'b1;
        end
    end
    assign disp_wr_n = disp_wr_n_reg;
    assign disp_ad = disp_ad_reg;
    assign disp_cs1_n = disp_cs1_n_reg;
    assign disp_cs2_n = disp_cs2_n_reg;
    assign disp_data = disp_data_reg;
    // ==========================================
    // Assertions
    ready_after_keepoff_a:
        assert property (@(posedge aclk) disable iff (!aresetn)
            $rose(link_ready_reg) |-> $past(keep_cnt_reg) == `CLW_KEEPOFF_CYCLES && $past(start_ok))
        else $error("Link ready without full keep-off");
    sleep_clears_a:
        assert property (@(posedge aclk) disable iff (!aresetn)
            sleep_a |=> !link_ready_reg && keep_cnt_reg == 11'h000)
        else $error("Sleep did not clear keep-off state");
    mult_decode_a:
        assert property (@(posedge aclk) disable iff (!aresetn)
            sel_s == 2'h1 |=> pll_multiplier == 8'h0A)
        else $error("Multiplier select 01 not decoded to 10");
    early_write_drop_a:
        assert property (@(posedge dc_clk) disable iff (!dc_rst_n_reg)
            wr_evt && !link_ready_dc |=> flag_reg[0] && fifo_cnt_reg == '0)
        else $error("Write before ready was not discarded");
    word_length_a:
        assert property (@(posedge dc_clk) disable iff (!dc_rst_n_reg)
            !tx_idle && tx_cnt_reg == 4'h0 && link_ready_dc |-> $past(tx_load, 14))
        else $error("Serial word not 14 cycles long");
    sync_after_gap_a:
        assert property (@(posedge dc_clk) disable iff (!dc_rst_n_reg)
            bit_sync_reg |-> $past(tx_idle) && $past(tx_idle, 2))
        else $error("Bit sync without idle gap");
    overflow_loss_a:
        assert property (@(posedge dc_clk) disable iff (!dc_rst_n_reg)
            wr_evt && link_ready_dc && fifo_full |=> flag_reg[1]
                && fifo_cnt_reg <= $past(fifo_cnt_reg))
        else $error("Overflow not flagged or surplus stored");
    strobe_width_a:
        assert property (@(posedge dc_clk) disable iff (!dc_rst_n_reg)
            $fell(disp_wr_n_reg) |-> ##11 !disp_wr_n_reg ##1 disp_wr_n_reg)
        else $error("Write strobe not twelve cycles low");
    lane_swap_a:
        assert property (@(posedge dc_clk) disable iff (!dc_rst_n_reg)
            !master_s |=> !lane0_en && !lane1_en && lane1_tx == 2'h0)
        else $error("Slave role drives lane pads");
    word_sent_c: cover property (@(posedge dc_clk) disable iff (!dc_rst_n_reg) tx_load);
    strobe_c: cover property (@(posedge dc_clk) disable iff (!dc_rst_n_reg) $fell(disp_wr_n_reg));
    overflow_c: cover property (@(posedge dc_clk) disable iff (!dc_rst_n_reg) flag_set[1]);
    drop_c: cover property (@(posedge dc_clk) disable iff (!dc_rst_n_reg) flag_set[0]);
endmodule

// ==== clw_defs.svh ====
`ifndef CLW_DEFS_SVH
`define CLW_DEFS_SVH
// ==========================================
// Register map
`define CLW_CTRL_OFF 8'h00
`define CLW_STAT_OFF 8'h04
`define CLW_MULT_OFF 8'h08
`define CLW_CTRL_RST 1'h1
`define CLW_CTRL_EN_BIT 0
`define CLW_ST_READY_BIT 0
`define CLW_ST_LOCK_BIT 1
`define CLW_ST_SLEEP_BIT 2
`define CLW_ST_DROP_BIT 3
`define CLW_ST_OVF_BIT 4
`define CLW_ST_RSVD_BIT 5
// ==========================================
// Multiplier select decode
`define CLW_MULT_SEL0 8'h08
`define CLW_MULT_SEL1 8'h0A
`define CLW_MULT_SEL2 8'h0C
`define CLW_SEL_RSVD 2'h3
// ==========================================
// Timing counts
`define CLW_KEEPOFF_CYCLES 11'h400
`define CLW_WORD_DC_CYCLES 4'hE
`define CLW_STROBE_DC_CYCLES 4'hC
`define CLW_STOP_DC_CYCLES 5'h10
`define CLW_SYNC_GAP_DC 5'h02
// ==========================================
// Frame layout and lane codes
`define CLW_ENTRY_W 21
`define CLW_FRAME_W 28
`define CLW_START_CODE 2'h2
`define CLW_SYNC_CODE 2'h1
`define CLW_CLK_CODE 2'h2
`define CLW_TRAILER 5'h00
`endif

// ==== clw_pkg.sv ====
package clw_pkg;
    typedef logic [1:0] clw_lane_t;
    typedef enum logic [1:0] {CLW_TX_IDLE, CLW_TX_SEND} clw_tx_state_t;
    typedef enum logic [1:0] {CLW_RX_HUNT, CLW_RX_SHIFT} clw_rx_state_t;
endpackage

// ==== clw_host_model.sv ====
module clw_host_model (
    input wire logic dc_clk,
    output logic host_wr_n,
    output logic host_ad,
    output logic host_cs1_n,
    output logic host_cs2_n,
    output logic [17:0] host_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // Host bus writer
    initial begin
        host_wr_n = 1'b1;
        {host_ad, host_cs1_n, host_cs2_n, host_data} = 21'h1F_FFFF;
    end
    // Data flipped after the strobe so a stale word never looks valid
    task automatic put(input logic [20:0] w);
        @(posedge dc_clk);
        {host_ad, host_cs1_n, host_cs2_n, host_data} <= w;
        host_wr_n <= 1'b0;
        repeat (2) @(posedge dc_clk);
        host_wr_n <= 1'b1;
        @(posedge dc_clk);
        {host_cs1_n, host_cs2_n} <= 2'b11;
        host_data <= ~w[17:0];
    endtask
endmodule

// ==== tb_cpu_link_startup_write_pacing.sv ====
`include "clw_defs.svh"
module tb_cpu_link_startup_write_pacing;
    timeunit 1ns;
    timeprecision 1ps;
    import clw_pkg::*;
    logic aclk = 1'b0, dc_clk = 1'b0, aresetn = 1'b0, power_down_n = 1'b0, pll_locked = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, pmul;
    logic [31:0] wdata = 32'h0000_0000, rdata, rv;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] msel = 2'h0, bresp, rresp, rr, br;
    logic awready, wready, bvalid, arready, rvalid, m0en, m1en, s0en, s1en;
    logic h_wr_n, h_ad, h_cs1_n, h_cs2_n, d_wr_n, d_ad, d_cs1_n, d_cs2_n;
    logic [17:0] h_data, d_data;
    clw_lane_t ln_a, ln_b, m0tx, m1tx, s0tx, s1tx;
    int fails = 0, num_checks = 0, cyc = 0, nstb = 0, b;
    logic [7:0] mx [4] = '{8'h08, 8'h0A, 8'h0C, 8'h00};
    // ========================================
    // Clocks, lanes and instances
    always #25 aclk = ~aclk;
    always #32 dc_clk = ~dc_clk;
    // Released lanes assumed pulled low
    assign ln_a = m0en ? m0tx : (s1en ? s1tx : 2'b00);
    assign ln_b = m1en ? m1tx : (s0en ? s0tx : 2'b00);
    always @(negedge d_wr_n) nstb++;
    clw_host_model u_host (.dc_clk(dc_clk), .host_wr_n(h_wr_n), .host_ad(h_ad),
        .host_cs1_n(h_cs1_n), .host_cs2_n(h_cs2_n), .host_data(h_data));
    clw_bridge u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .power_down_n(power_down_n), .pll_locked(pll_locked), .multiplier_select(msel),
        .pll_multiplier(pmul), .master_role(1'b1), .dc_clk(dc_clk), .host_wr_n(h_wr_n),
        .host_ad(h_ad), .host_cs1_n(h_cs1_n), .host_cs2_n(h_cs2_n), .host_data(h_data),
        .lane0_rx(ln_a), .lane0_tx(m0tx), .lane0_en(m0en), .lane1_rx(ln_b), .lane1_tx(m1tx),
        .lane1_en(m1en), .disp_wr_n(), .disp_ad(), .disp_cs1_n(), .disp_cs2_n(), .disp_data());
    clw_bridge u_far (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(), .bresp(), .bvalid(),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(), .rresp(),
        .rvalid(), .rready(rready), .power_down_n(power_down_n), .pll_locked(pll_locked),
        .multiplier_select(msel), .pll_multiplier(), .master_role(1'b0), .dc_clk(dc_clk),
        .host_wr_n(h_wr_n), .host_ad(h_ad), .host_cs1_n(h_cs1_n), .host_cs2_n(h_cs2_n),
        .host_data(h_data), .lane0_rx(ln_b), .lane0_tx(s0tx), .lane0_en(s0en),
        .lane1_rx(ln_a), .lane1_tx(s1tx), .lane1_en(s1en), .disp_wr_n(d_wr_n),
        .disp_ad(d_ad), .disp_cs1_n(d_cs1_n), .disp_cs2_n(d_cs2_n), .disp_data(d_data));
    // ========================================
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        fork
            begin
                do @(posedge aclk); while (awready !== 1'b1);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (wready !== 1'b1);
                wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        br = bresp;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        rv = rdata;
        rr = rresp;
    endtask
    task automatic frm(input logic [20:0] w);
        logic [25:0] sh;
        logic sy;
        int n, c;
        sy = 1'b0;
        n = 0;
        c = 0;
        fork
            u_host.put(w);
            begin
                do begin
                    @(posedge dc_clk);
                    n++;
                    sy |= (m0tx === 2'b01);
                end while (m0tx !== 2'b10 && n < 300);
                repeat (13) begin
                    @(posedge dc_clk);
                    sh = {sh[23:0], m0tx};
                end
            end
            begin
                while (d_wr_n !== 1'b0 && c < 400) begin
                    @(posedge dc_clk);
                    c++;
                end
                chk({d_ad, d_cs1_n, d_cs2_n, d_data}, w, "display word");
                c = 0;
                do begin
                    @(posedge dc_clk);
                    c++;
                end while (d_wr_n === 1'b0 && c < 40);
            end
        join
        chk(sh, {w, 5'h00}, "frame");
        chk(sy, 1'b1, "sync");
        chk(c, 32'h0000_000C, "strobe width");
    endtask
    // ========================================
    // Timeout and sequence
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            msel <= i[1:0];
            repeat (8) @(posedge aclk);
            axr(`CLW_MULT_OFF);
            chk(pmul, mx[i], "multiplier pin");
            chk(rv, mx[i], "multiplier reg");
        end
        msel <= 2'h0;
        $display("multiplier test done");
        power_down_n <= 1'b1;
        repeat (4) @(posedge dc_clk);
        u_host.put(21'h0A_BCDE);
        repeat (880) @(posedge aclk);
        axr(`CLW_STAT_OFF);
        chk({rv[0], m1tx}, 3'b000, "early ready");
        repeat (180) @(posedge aclk);
        axr(`CLW_STAT_OFF);
        chk(rv[5:0], 6'h0B, "ready and dropped");
        chk(nstb, 32'h0000_0000, "nothing delivered");
        chk({m0en, m1en, s0en, s1en, m1tx}, 6'b110010, "lane roles");
        axw(`CLW_STAT_OFF, 32'h0000_0008);
        repeat (10) @(posedge aclk);
        axr(`CLW_STAT_OFF);
        chk(rv[3], 1'b0, "sticky clear");
        $display("start-up test done");
        for (int k = 0; k < 2; k++) begin
            frm({k[0], k[0], !k[0], k[0] ? 18'h2_A5C3 : 18'h1_5A3C});
        end
        $display("frame test done");
        b = nstb;
        repeat (5) u_host.put(21'h15_5555);
        repeat (200) @(posedge dc_clk);
        axr(`CLW_STAT_OFF);
        chk(rv[4], 1'b1, "overflow flag");
        chk(nstb - b < 5, 1'b1, "surplus lost");
        $display("overflow test done");
        power_down_n <= 1'b0;
        repeat (10) @(posedge aclk);
        axr(`CLW_STAT_OFF);
        chk(rv[2:0], 3'b110, "sleep");
        power_down_n <= 1'b1;
        repeat (40) @(posedge aclk);
        axr(`CLW_STAT_OFF);
        chk(rv[2:0], 3'b010, "count restarted");
        axr(8'h40);
        chk({rr, rv[29:0]}, 32'h8000_0000, "unmapped read");
        $display("sleep test done");
        stop_test();
    end
endmodule
